// ---- rtl/p7mux_top.sv ----
// p7mux_top: port 7 latch, direction register and pin function mux
// assumes pins are asynchronous; serial engines and mode are same clock
`timescale 1ns/1ps
module p7mux_top
   import p7mux_pkg::*;
(
   input  wire  logic                    MCLK,         // 40 mhz clock
   input  wire  logic                    SYS_RST,      // sync reset, high
   input  wire  logic [P7MUX_AW-1:0]     AVS_ADDRESS,  // byte address
   input  wire  logic                    AVS_READ,     // read request
   input  wire  logic                    AVS_WRITE,    // write request
   input  wire  logic [31:0]             AVS_WRITEDATA, // write data
   input  wire  logic [3:0]              AVS_BYTEENABLE, // byte lanes
   output logic [31:0]                   AVS_READDATA, // read data
   output logic                          AVS_WAITREQUEST, // wait
   input  wire  logic                    SER1_CLK_OUT, // channel 1 clock
   input  wire  logic                    SER1_TX_DATA, // channel 1 tx data
   input  wire  logic                    SER2_CLK_OUT, // channel 2 clock
   input  wire  logic                    SER2_TX_DATA, // channel 2 tx data
   input  wire  logic                    PAGE_ADDR_TOP_BIT, // address bit
   output logic                          SER1_CLK_IN,  // synced clock 1
   output logic                          SER1_RX_DATA, // synced rx 1
   output logic                          SER2_CLK_IN,  // synced clock 2
   output logic                          SER2_RX_DATA, // synced rx 2
   output logic                          SYS_CLK_OUT_EN, // clock out enable
   input  wire  logic [P7MUX_NPIN-1:0]   PORT7_IN,     // pin levels
   output logic [P7MUX_NPIN-1:0]         PORT7_OUT,    // pin drive values
   output logic [P7MUX_NPIN-1:0]         PORT7_OE      // pin drive enables
);
   import p7mux_pkg::*;

   // ==========================================================
   // register state
   logic [7:0]            latch_ff;
   logic [7:0]            dir_ff;
   logic [2:0]            mode_ff;
   logic                  rst_seen_ff;
   p7mux_ser_s            ser1_ff;
   p7mux_ser_s            ser2_ff;
   logic [P7MUX_NPIN-1:0] sync1_ff;
   logic [P7MUX_NPIN-1:0] sync2_ff;
   logic                  ack_ff;
   logic [31:0]           rdata_ff;
   logic [15:0]           idx;
   logic                  req;
   logic                  sel_dir;
   logic                  sel_latch;
   logic                  sel_mode;
   logic                  sel_ser;
   logic                  sel_stat;
   logic [7:0]            nxt_read;
   logic                  mapped;

   assign idx       = AVS_ADDRESS[P7MUX_AW-1:2];
   assign req       = (AVS_READ | AVS_WRITE) & ~ack_ff;
   assign sel_dir   = (idx == P7MUX_DIR_IDX);
   assign sel_latch = (idx == P7MUX_LATCH_IDX);
   assign sel_mode  = (idx == P7MUX_MODE_IDX);
   assign sel_ser   = (idx == P7MUX_SER_IDX);
   assign sel_stat  = (idx == P7MUX_STAT_IDX);
   assign mapped    = sel_dir | sel_latch | sel_mode | sel_ser | sel_stat;

   // ==========================================================
   // bus handshake: one wait cycle, then ack for one cycle
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         ack_ff <= 1'b0;
      end
      else
      begin
         ack_ff <= req;
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         AVS_WAITREQUEST <= 1'b1;
      end
      else
      begin
         AVS_WAITREQUEST <= ~req;
      end
   end

   // ==========================================================
   // operating mode register; reset state is mode 7
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         mode_ff <= P7MUX_MODE_RST;
      end
      else if (req & AVS_WRITE & sel_mode & AVS_BYTEENABLE[0])
      begin
         mode_ff <= AVS_WRITEDATA[2:0];
      end
   end

   // tracks the first cycle after reset to apply the direction reset value chosen by the mode
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         rst_seen_ff <= 1'b0;
      end
      else
      begin
         rst_seen_ff <= 1'b1;
      end
   end

   // ==========================================================
   // serial control: bits [4:0] channel one, [12:8] channel two
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         ser1_ff <= '0;
      end
      else if (req & AVS_WRITE & sel_ser & AVS_BYTEENABLE[0])
      begin
         ser1_ff <= AVS_WRITEDATA[4:0];
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         ser2_ff <= '0;
      end
      else if (req & AVS_WRITE & sel_ser & AVS_BYTEENABLE[1])
      begin
         ser2_ff <= AVS_WRITEDATA[12:8];
      end
   end

   // ==========================================================
   // direction register; reset value follows the mode
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         dir_ff <= P7MUX_DIR_RST_SC;
      end
      else if (!rst_seen_ff)
      begin
         dir_ff <= (mode_ff == P7MUX_MODE7) ? P7MUX_DIR_RST_SC
                                            : P7MUX_DIR_RST_EX;
      end
      else if (req & AVS_WRITE & sel_dir & AVS_BYTEENABLE[0])
      begin
         dir_ff <= AVS_WRITEDATA[7:0];
      end
   end

   // ==========================================================
   // output latch; upper two bits never store
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         latch_ff <= P7MUX_LATCH_RST;
      end
      else if (req & AVS_WRITE & sel_latch & AVS_BYTEENABLE[0])
      begin
         latch_ff <= {2'b00, AVS_WRITEDATA[5:0]};
      end
   end

   // ==========================================================
   // pin synchronisers
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end
      else
      begin
         sync1_ff <= PORT7_IN;
         sync2_ff <= sync1_ff;
      end
   end

   // ==========================================================
   // pin function decode
   p7mux_ck_e             ck1_role;
   p7mux_ck_e             ck2_role;
   logic [P7MUX_NPIN-1:0] nxt_oe;
   logic [P7MUX_NPIN-1:0] nxt_out;
   logic                  ser_zero2;

   p7mux_ckdec u_ck1 (
      .ser  (ser1_ff),
      .role (ck1_role)
   );

   p7mux_ckdec u_ck2 (
      .ser  (ser2_ff),
      .role (ck2_role)
   );

   assign ser_zero2 = ~(ser2_ff.sync_sel | ser2_ff.clock_enable_high |
                        ser2_ff.clock_enable_low);

   always_comb
   begin
      // default gpio role from direction bits
      nxt_oe  = dir_ff[5:0];
      nxt_out = latch_ff[5:0];
      // channel one clock, same in all modes
      if (ck1_role == P7MUX_CK_OUT)
      begin
         nxt_oe[P7MUX_CK1]  = 1'b1;
         nxt_out[P7MUX_CK1] = SER1_CLK_OUT;
      end
      else if (ck1_role == P7MUX_CK_IN)
      begin
         nxt_oe[P7MUX_CK1]  = 1'b0;
      end
      else
      begin
         nxt_oe[P7MUX_CK1]  = dir_ff[P7MUX_CK1];
      end
      if (ser1_ff.rx_on_bit)
      begin
         nxt_oe[P7MUX_RX1] = 1'b0;
      end
      if (ser1_ff.tx_on_bit)
      begin
         nxt_oe[P7MUX_TX1]  = 1'b1;
         nxt_out[P7MUX_TX1] = SER1_TX_DATA;
      end
      if (ser2_ff.rx_on_bit)
      begin
         nxt_oe[P7MUX_RX2] = 1'b0;
      end
      if (ser2_ff.tx_on_bit)
      begin
         nxt_oe[P7MUX_TX2]  = 1'b1;
         nxt_out[P7MUX_TX2] = SER2_TX_DATA;
      end
      // channel two clock pin depends on mode
      case (mode_ff)
         P7MUX_MODE3:
         begin
            nxt_oe[P7MUX_CK2]  = 1'b1;
            nxt_out[P7MUX_CK2] = PAGE_ADDR_TOP_BIT;
         end
         P7MUX_MODE4:
         begin
            if (dir_ff[P7MUX_CK2])
            begin
               nxt_oe[P7MUX_CK2]  = 1'b1;
               nxt_out[P7MUX_CK2] = PAGE_ADDR_TOP_BIT;
            end
            else if (ser_zero2 || ck2_role != P7MUX_CK_OUT)
            begin
               nxt_oe[P7MUX_CK2] = 1'b0;
            end
            else
            begin
               nxt_oe[P7MUX_CK2]  = 1'b1;
               nxt_out[P7MUX_CK2] = SER2_CLK_OUT;
            end
         end
         default:
         begin
            if (ck2_role == P7MUX_CK_OUT)
            begin
               nxt_oe[P7MUX_CK2]  = 1'b1;
               nxt_out[P7MUX_CK2] = SER2_CLK_OUT;
            end
            else if (ck2_role == P7MUX_CK_IN)
            begin
               nxt_oe[P7MUX_CK2] = 1'b0;
            end
            else
            begin
               nxt_oe[P7MUX_CK2] = dir_ff[P7MUX_CK2];
            end
         end
      endcase
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         PORT7_OE  <= '0;
         PORT7_OUT <= '0;
      end
      else
      begin
         PORT7_OE  <= nxt_oe;
         PORT7_OUT <= nxt_out;
      end
   end

   // synced pin levels toward the serial channels and clock out enable
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         SER1_CLK_IN    <= 1'b0;
         SER1_RX_DATA   <= 1'b0;
         SER2_CLK_IN    <= 1'b0;
         SER2_RX_DATA   <= 1'b0;
         SYS_CLK_OUT_EN <= 1'b0;
      end
      else
      begin
         SER1_CLK_IN    <= sync2_ff[P7MUX_CK1];
         SER1_RX_DATA   <= sync2_ff[P7MUX_RX1];
         SER2_CLK_IN    <= sync2_ff[P7MUX_CK2];
         SER2_RX_DATA   <= sync2_ff[P7MUX_RX2];
         SYS_CLK_OUT_EN <= dir_ff[P7MUX_CLKOUT_BIT];
      end
   end

   // ==========================================================
   // read path
   always_comb
   begin
      nxt_read = 8'h00;
      if (sel_latch)
      begin
         // output pins give latch, input pins give pin level
         nxt_read[5:0] = (latch_ff[5:0] & PORT7_OE) |
                         (sync2_ff & ~PORT7_OE);
      end
      else if (sel_dir)
      begin
         nxt_read = P7MUX_DIR_RD;
      end
      else if (sel_mode)
      begin
         nxt_read = {5'b00000, mode_ff};
      end
      else if (sel_ser)
      begin
         nxt_read = {3'b000, ser1_ff};
      end
      else if (sel_stat)
      begin
         nxt_read = {2'b00, PORT7_OE};
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         rdata_ff <= P7MUX_UNMAPPED;
      end
      else if (req & AVS_READ)
      begin
         if (sel_ser)
         begin
            rdata_ff <= {19'h0_0000, ser2_ff, 3'b000, ser1_ff};
         end
         else if (mapped)
         begin
            rdata_ff <= {24'h00_0000, nxt_read};
         end
         else
         begin
            rdata_ff <= P7MUX_UNMAPPED;
         end
      end
   end

   assign AVS_READDATA = rdata_ff;
endmodule : p7mux_top

// ---- rtl/p7mux_pkg.sv ----
// p7mux_pkg: constants and carrier types for the port 7 pin mux block
// assumes a 32-bit avalon-mm register bus with word addressing in bytes
package p7mux_pkg;
   // register word indices; the byte address is four times the index
   localparam logic [15:0] P7MUX_DIR_IDX    = 16'hFF8C;
   localparam logic [15:0] P7MUX_LATCH_IDX  = 16'hFF8E;
   localparam logic [15:0] P7MUX_MODE_IDX   = 16'hFF80;
   localparam logic [15:0] P7MUX_SER_IDX    = 16'hFF81;
   localparam logic [15:0] P7MUX_STAT_IDX   = 16'hFF82;
   localparam int          P7MUX_AW         = 18;
   localparam int          P7MUX_NPIN       = 6;
   localparam logic [7:0]  P7MUX_LATCH_RST  = 8'h00;
   localparam logic [7:0]  P7MUX_DIR_RST_EX = 8'h40;
   localparam logic [7:0]  P7MUX_DIR_RST_SC = 8'h00;
   localparam logic [7:0]  P7MUX_DIR_RD     = 8'hFF;
   localparam logic [5:0]  P7MUX_PIN_MASK   = 6'h3F;
   localparam logic [2:0]  P7MUX_MODE_RST   = 3'h7;
   localparam logic [31:0] P7MUX_UNMAPPED   = 32'h0000_0000;
   // pin positions in the port
   localparam int P7MUX_TX2 = 0;
   localparam int P7MUX_RX2 = 1;
   localparam int P7MUX_CK2 = 2;
   localparam int P7MUX_TX1 = 3;
   localparam int P7MUX_RX1 = 4;
   localparam int P7MUX_CK1 = 5;
   localparam int P7MUX_CLKOUT_BIT = 6;
   // operating modes
   localparam logic [2:0] P7MUX_MODE3 = 3'h3;
   localparam logic [2:0] P7MUX_MODE4 = 3'h4;
   localparam logic [2:0] P7MUX_MODE7 = 3'h7;

   // per-channel serial control bits
   typedef struct packed {
      logic sync_sel;
      logic clock_enable_high;
      logic clock_enable_low;
      logic rx_on_bit;
      logic tx_on_bit;
   } p7mux_ser_s;

   // decoded role of a serial clock pin
   typedef enum logic [1:0] {
      P7MUX_CK_GPIO,
      P7MUX_CK_OUT,
      P7MUX_CK_IN
   } p7mux_ck_e;
endpackage : p7mux_pkg

// ---- rtl/p7mux_ckdec.sv ----
// p7mux_ckdec: decodes one serial clock pin role from its control bits
// assumes pure combinational use inside the port 7 mux
`timescale 1ns/1ps
module p7mux_ckdec
   import p7mux_pkg::*;
(
   input  wire p7mux_pkg::p7mux_ser_s ser,  // channel control bits
   output p7mux_pkg::p7mux_ck_e       role  // decoded pin role
);
   always_comb
   begin
      if (ser.sync_sel)
      begin
         // clock enable low ignored in sync mode
         role = ser.clock_enable_high ? P7MUX_CK_IN : P7MUX_CK_OUT;
      end
      else if (ser.clock_enable_high)
      begin
         role = P7MUX_CK_IN;
      end
      else if (ser.clock_enable_low)
      begin
         role = P7MUX_CK_OUT;
      end
      else
      begin
         role = P7MUX_CK_GPIO;
      end
   end
endmodule : p7mux_ckdec

// ---- testbench/p7mux_chk.sv ----
// p7mux_chk: port assertions for the port 7 pin mux
// assumes bind into p7mux_top; registers shadowed from bus writes
`timescale 1ns/1ps
module p7mux_chk
   import p7mux_pkg::*;
(
   input wire logic                  MCLK,              // clock
   input wire logic                  SYS_RST,           // reset
   input wire logic [P7MUX_AW-1:0]   AVS_ADDRESS,       // address
   input wire logic                  AVS_READ,          // read
   input wire logic                  AVS_WRITE,         // write
   input wire logic [31:0]           AVS_WRITEDATA,     // wdata
   input wire logic [31:0]           AVS_READDATA,      // rdata
   input wire logic                  AVS_WAITREQUEST,   // wait
   input wire logic                  SER1_TX_DATA,      // tx 1
   input wire logic                  PAGE_ADDR_TOP_BIT, // page bit
   input wire logic                  SER1_RX_DATA,      // rx 1
   input wire logic                  SYS_CLK_OUT_EN,    // clock out
   input wire logic [P7MUX_NPIN-1:0] PORT7_IN,          // levels
   input wire logic [P7MUX_NPIN-1:0] PORT7_OUT,         // drive
   input wire logic [P7MUX_NPIN-1:0] PORT7_OE           // enables
);
   localparam logic [P7MUX_AW-1:0] a_lat  = {P7MUX_LATCH_IDX, 2'b00};
   localparam logic [P7MUX_AW-1:0] a_dir  = {P7MUX_DIR_IDX, 2'b00};
   localparam logic [P7MUX_AW-1:0] a_mode = {P7MUX_MODE_IDX, 2'b00};
   localparam logic [P7MUX_AW-1:0] a_ser  = {P7MUX_SER_IDX, 2'b00};
   logic [5:0]  lat_ff;
   logic [7:0]  dir_ff;
   logic [2:0]  mode_ff;
   logic [12:0] ser_ff;
   logic [1:0]  cnt_ff;
   logic        wr_done;
   logic        settled;
   assign wr_done = AVS_WRITE && !AVS_WAITREQUEST;
   assign settled = (cnt_ff == 2'h3);
   // ==========================================
   // register shadows
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
      begin
         lat_ff  <= 6'h00;
         dir_ff  <= P7MUX_DIR_RST_SC;
         mode_ff <= P7MUX_MODE_RST;
         ser_ff  <= 13'h0000;
      end
      else if (wr_done)
      begin
         if (AVS_ADDRESS == a_lat)
            lat_ff <= AVS_WRITEDATA[5:0];
         if (AVS_ADDRESS == a_dir)
            dir_ff <= AVS_WRITEDATA[7:0];
         if (AVS_ADDRESS == a_mode)
            mode_ff <= AVS_WRITEDATA[2:0];
         if (AVS_ADDRESS == a_ser)
            ser_ff <= AVS_WRITEDATA[12:0];
      end
   end
   // pins are only judged once every pipeline stage has caught up
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST || wr_done)
         cnt_ff <= 2'h0;
      else if (!settled)
         cnt_ff <= cnt_ff + 2'h1;
   end
   // ==========================================
   // assertions
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SYS_RST);
   sequence s_taken;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   sequence s_answer;
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endsequence
   sequence s_rd(logic [P7MUX_AW-1:0] a);
      AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == a;
   endsequence
   chk_bus_answer: assert property (s_taken |=> s_answer)
      else $error("request not answered after one wait state");
   chk_dir_ones: assert property (
      s_rd(a_dir) |=> AVS_READDATA[7:0] == P7MUX_DIR_RD)
      else $error("direction read is not all ones");
   chk_latch_top: assert property (
      s_rd(a_lat) |=> AVS_READDATA[7:6] == 2'b00)
      else $error("reserved latch bits read nonzero");
   chk_out_readback: assert property (
      s_rd(a_lat) ##0 settled |=>
      ((AVS_READDATA[5:0] ^ lat_ff) & $past(PORT7_OE)) == 6'h00)
      else $error("output pin read differs from latch");
   chk_tx1_drive: assert property (
      settled && ser_ff[0] |-> PORT7_OE[P7MUX_TX1] &&
      PORT7_OUT[P7MUX_TX1] == $past(SER1_TX_DATA))
      else $error("tx1 pin not driving transmit data");
   chk_rx_input: assert property (
      settled |-> !(ser_ff[1] && PORT7_OE[P7MUX_RX1]) &&
      !(ser_ff[9] && PORT7_OE[P7MUX_RX2]))
      else $error("receive pin driven while receiver on");
   chk_gpio_tx1: assert property (
      settled && !ser_ff[0] |-> PORT7_OE[3] == dir_ff[3] &&
      (!dir_ff[3] || PORT7_OUT[3] == lat_ff[3]))
      else $error("tx1 general pin ignores direction or latch");
   chk_addr_drive: assert property (
      settled && (mode_ff == P7MUX_MODE3 ||
      (mode_ff == P7MUX_MODE4 && dir_ff[2])) |-> PORT7_OE[2] &&
      PORT7_OUT[2] == $past(PAGE_ADDR_TOP_BIT))
      else $error("clock2 pin not driving page address bit");
   chk_clkout_copy: assert property (
      settled |-> SYS_CLK_OUT_EN == dir_ff[P7MUX_CLKOUT_BIT])
      else $error("clock output enable differs from direction bit");
   chk_rx1_sync: assert property (
      settled && ser_ff[1] |->
      SER1_RX_DATA == $past(PORT7_IN[P7MUX_RX1], 3))
      else $error("rx1 data not following pin after sync");
endmodule : p7mux_chk
bind p7mux_top p7mux_chk p7mux_chk_i (
   .MCLK(MCLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .SER1_TX_DATA(SER1_TX_DATA),
   .PAGE_ADDR_TOP_BIT(PAGE_ADDR_TOP_BIT), .SER1_RX_DATA(SER1_RX_DATA),
   .SYS_CLK_OUT_EN(SYS_CLK_OUT_EN), .PORT7_IN(PORT7_IN),
   .PORT7_OUT(PORT7_OUT), .PORT7_OE(PORT7_OE)
);

// ---- testbench/p7mux_pins.sv ----
// p7mux_pins: external peers on the port 7 pins
// assumes pull-ups on every pin; peers drive only when enabled
`timescale 1ns/1ps
module p7mux_pins
   import p7mux_pkg::*;
(
   input  wire logic [P7MUX_NPIN-1:0] pin_out, // block values
   input  wire logic [P7MUX_NPIN-1:0] pin_oe,  // block enables
   input  wire logic [P7MUX_NPIN-1:0] ext_val, // peer values
   input  wire logic [P7MUX_NPIN-1:0] ext_en,  // peer enables
   output logic      [P7MUX_NPIN-1:0] pin_lvl  // pin levels
);
   // ==========================================
   // pin resolution
   always_comb
   begin
      for (int i = 0; i < P7MUX_NPIN; i++)
         pin_lvl[i] = pin_oe[i] ? pin_out[i] :
                      (ext_en[i] ? ext_val[i] : 1'b1);
   end
endmodule : p7mux_pins

// ---- testbench/p7mux_tb.sv ----
// p7mux_tb: register-level bench for the port 7 pin mux
// assumes p7mux_top, the p7mux_pins peers and the bound checker
`timescale 1ns/1ps
module p7mux_tb;
   import p7mux_pkg::*;
   logic                  mclk;
   logic                  sys_rst;
   logic [P7MUX_AW-1:0]   avs_address;
   logic                  avs_read;
   logic                  avs_write;
   logic [31:0]           avs_writedata;
   logic [3:0]            avs_byteenable;
   logic [31:0]           avs_readdata;
   logic                  avs_waitrequest;
   logic [3:0]            ser_drv;
   logic                  page_bit;
   logic [3:0]            rx_data;
   logic                  clk_out_en;
   logic [P7MUX_NPIN-1:0] port_in;
   logic [P7MUX_NPIN-1:0] port_out;
   logic [P7MUX_NPIN-1:0] port_oe;
   logic [P7MUX_NPIN-1:0] ext_val;
   logic [P7MUX_NPIN-1:0] ext_en;
   int                    errors;
   int                    comparisons;
   p7mux_top p7mux_top_i (
      .MCLK(mclk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read), .AVS_WRITE(avs_write),
      .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
      .SER1_CLK_OUT(ser_drv[3]), .SER1_TX_DATA(ser_drv[2]),
      .SER2_CLK_OUT(ser_drv[1]), .SER2_TX_DATA(ser_drv[0]),
      .PAGE_ADDR_TOP_BIT(page_bit), .SER1_CLK_IN(rx_data[3]),
      .SER1_RX_DATA(rx_data[1]), .SER2_CLK_IN(rx_data[2]),
      .SER2_RX_DATA(rx_data[0]), .SYS_CLK_OUT_EN(clk_out_en),
      .PORT7_IN(port_in), .PORT7_OUT(port_out), .PORT7_OE(port_oe)
   );
   p7mux_pins p7mux_pins_i (
      .pin_out(port_out), .pin_oe(port_oe), .ext_val(ext_val),
      .ext_en(ext_en), .pin_lvl(port_in)
   );
   // ==========================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [15:0] idx,
                      input logic [31:0] d, output logic [31:0] q);
      avs_address    <= {idx, 2'b00};
      avs_writedata  <= d;
      avs_byteenable <= (idx == P7MUX_SER_IDX) ? 4'h3 : 4'h1;
      avs_write      <= wr;
      avs_read       <= !wr;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0)
         @(posedge mclk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge mclk);
   endtask : bus
   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask : wr
   task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, idx, 32'h0000_0000, q);
      chk(q, exp);
   endtask : rd
   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : do_reset
   // expected drive enable of a serial clock pin
   function automatic logic ck_oe(input logic [2:0] c, input logic d);
      ck_oe = (c[2] ? !c[1] : (!c[1] && c[0])) || (c == 3'h0 && d);
   endfunction : ck_oe
   task automatic sweep(input logic [2:0] m);
      logic [2:0] c;
      logic [7:0] d;
      logic       a2;
      logic       e2;
      logic [5:0] eoe;
      logic [5:0] eo;
      wr(P7MUX_MODE_IDX, 32'(m));
      for (int k = 0; k < 16; k++)
      begin
         c = k[2:0];
         d = k[3] ? 8'h24 : 8'h00;
         a2 = (m == P7MUX_MODE3) || (m == P7MUX_MODE4 && d[2]);
         e2 = a2 || ck_oe(c, d[2]);
         eoe = {ck_oe(c, d[5]), 2'h0, e2, 2'h0};
         // clock1 out drives 1, clock2 out drives !c[0], latch bit 2 is 1
         eo = {ck_oe(c, 1'b0), 2'h0,
               (a2 ? c[0] : (!ck_oe(c, 1'b0) || !c[0])), 2'h0};
         page_bit <= c[0];
         ser_drv <= {1'b1, 1'b0, !c[0], 1'b0};
         wr(P7MUX_DIR_IDX, 32'(d));
         wr(P7MUX_SER_IDX, {19'h0_0000, c, 5'h00, c, 2'h0});
         rd(P7MUX_STAT_IDX, 32'(eoe));
         chk(32'(port_out & eoe), 32'(eo & eoe));
      end
   endtask : sweep
   task automatic end_of_test();
      if (errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   // ==========================================
   // clock, watchdog and test sequence
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial
   begin
      repeat (20000) @(posedge mclk);
      errors++;
      end_of_test();
   end
   initial
   begin
      errors = 0;
      comparisons = 0;
      avs_address <= 18'h0_0000;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= 32'h0000_0000;
      avs_byteenable <= 4'h0;
      ser_drv <= 4'h0;
      page_bit <= 1'b0;
      ext_val <= 6'h00;
      ext_en <= 6'h00;
      do_reset();
      rd(P7MUX_LATCH_IDX, 32'h0000_003F);
      rd(P7MUX_DIR_IDX, 32'h0000_00FF);
      rd(16'h0100, 32'h0000_0000);
      chk(32'(clk_out_en), 32'h0000_0000);
      wr(P7MUX_DIR_IDX, 32'h0000_003F);
      wr(P7MUX_LATCH_IDX, 32'h0000_00FF);
      rd(P7MUX_LATCH_IDX, 32'h0000_003F);
      chk(32'(port_oe), 32'h0000_003F);
      chk(32'(port_out), 32'h0000_003F);
      ext_val <= 6'h2A;
      ext_en <= 6'h30;
      wr(P7MUX_DIR_IDX, 32'h0000_000F);
      wr(P7MUX_LATCH_IDX, 32'h0000_0005);
      rd(P7MUX_LATCH_IDX, 32'h0000_0025);
      ext_en <= 6'h00;
      ser_drv <= 4'h4;
      wr(P7MUX_DIR_IDX, 32'h0000_0000);
      wr(P7MUX_SER_IDX, 32'h0000_0101);
      rd(P7MUX_STAT_IDX, 32'h0000_0009);
      chk(32'(port_out & 6'h09), 32'h0000_0008);
      ext_val <= 6'h10;
      ext_en <= 6'h12;
      wr(P7MUX_DIR_IDX, 32'h0000_003F);
      wr(P7MUX_SER_IDX, 32'h0000_0202);
      rd(P7MUX_STAT_IDX, 32'h0000_002D);
      repeat (4) @(posedge mclk);
      chk(32'(rx_data), 32'h0000_0006);
      ext_en <= 6'h00;
      sweep(P7MUX_MODE7);
      sweep(3'h1);
      sweep(3'h2);
      sweep(P7MUX_MODE3);
      sweep(P7MUX_MODE4);
      wr(P7MUX_DIR_IDX, 32'h0000_0040);
      repeat (3) @(posedge mclk);
      chk(32'(clk_out_en), 32'h0000_0001);
      do_reset();
      chk(32'(clk_out_en), 32'h0000_0000);
      wr(P7MUX_DIR_IDX, 32'h0000_003F);
      rd(P7MUX_LATCH_IDX, 32'h0000_0000);
      end_of_test();
   end
endmodule : p7mux_tb
